// file: mpsc_regs.vh
`ifndef MPSC_REGS_VH
`define MPSC_REGS_VH
`define MPSC_IDX_PARAMS 8'he6
`define MPSC_IDX_MSTAT 8'he8
`define MPSC_IDX_CTRL 8'hea
`define MPSC_IDX_IRQ_STAT 8'hf8
`define MPSC_IDX_IRQ_MASK 8'hfa
`define MPSC_IDX_OPSTAT 8'hfc
`define MPSC_CTRL_SAVE 31
`define MPSC_CTRL_LOAD 30
`define MPSC_CTRL_FCLR 29
`define MPSC_CTRL_RCLR 28
`define MPSC_CTRL_KEY_HI 27
`define MPSC_CTRL_KEY_LO 20
`define MPSC_CTRL_ANG_HI 19
`define MPSC_CTRL_ANG_LO 11
`define MPSC_CTRL_WDOG 10
`define MPSC_RESET_WORD 32'h0000_0000
`define MPSC_IRQ_R 0
`define MPSC_IRQ_L 1
`define MPSC_IRQ_KE 2
`define MPSC_IRQ_MECH 3
`define MPSC_IRQ_NVM 4
`define MPSC_IRQ_WDOG 5
`define MPSC_IRQ_BITS 6
`endif

// file: mpsc_top.v
// Design decision made here: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "mpsc_regs.vh"
module mpsc_top #(
  parameter NVM_KEY = 8'h5a, // Unlock value, arbitrary
  parameter WDOG_CYCLES = 32'd125000
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [9:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output wire ack_o,
  input wire r_done_i,
  input wire [7:0] r_val_i,
  input wire l_done_i,
  input wire [7:0] l_val_i,
  input wire ke_done_i,
  input wire [7:0] ke_val_i,
  input wire mech_done_i,
  input wire [3:0] freq_val_i,
  input wire nvm_busy_i,
  input wire wdog_en_i,
  output reg nvm_save_o,
  output reg nvm_load_o,
  output reg fault_clear_o,
  output reg retry_clear_o,
  output reg [8:0] align_angle_o,
  output reg wdog_tickle_o,
  output reg wdog_timeout_o,
  output wire irq_o
);
  reg ack_r;
  reg [7:0] res_r, emf_r, ind_r;
  reg [3:0] freq_r;
  reg r_flag_r, l_flag_r, ke_flag_r, mech_flag_r;
  reg save_bit_r, load_bit_r, wdog_bit_r;
  reg [7:0] key_r;
  reg [8:0] angle_r;
  reg [`MPSC_IRQ_BITS-1:0] irq_stat_r, irq_mask_r, irq_set;
  reg [31:0] wdog_cnt_r;
  reg nvm_busy_d_r;
  wire [7:0] idx = adr_i[9:2];
  wire req = cyc_i & stb_i & ~ack_r;
  wire wr = req & we_i;
  wire wr_ctrl = wr & (idx == `MPSC_IDX_CTRL) & sel_i[3];
  wire key_ok = (dat_i[`MPSC_CTRL_KEY_HI:`MPSC_CTRL_KEY_LO] == NVM_KEY);
  wire nvm_done = nvm_busy_d_r & ~nvm_busy_i;
  wire wdog_expire = wdog_en_i & (wdog_cnt_r == WDOG_CYCLES - 32'd1);

  // Single-wait-state slave: ack one cycle after request, dropped after
  assign ack_o = ack_r;
  always @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  // Results change only on measurement completion; bus writes never reach them
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      res_r <= 8'h00;
      emf_r <= 8'h00;
      ind_r <= 8'h00;
      freq_r <= 4'h0;
      r_flag_r <= 1'b0;
      l_flag_r <= 1'b0;
      ke_flag_r <= 1'b0;
      mech_flag_r <= 1'b0;
    end
    else
    begin
      if (r_done_i)
      begin
        res_r <= r_val_i;
        r_flag_r <= 1'b1;
      end
      if (l_done_i)
      begin
        ind_r <= l_val_i;
        l_flag_r <= 1'b1;
        freq_r <= freq_val_i; // frequency follows the time constant
      end
      if (ke_done_i)
      begin
        emf_r <= ke_val_i;
        ke_flag_r <= 1'b1;
      end
      if (mech_done_i)
        mech_flag_r <= 1'b1;
    end
  end

  // Control word; each trigger write (save only with the key) yields a one-cycle output pulse, while the save/load bits hold until NVM busy falls
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      save_bit_r <= 1'b0;
      load_bit_r <= 1'b0;
      wdog_bit_r <= 1'b0;
      key_r <= 8'h00;
      angle_r <= 9'h000;
      nvm_save_o <= 1'b0;
      nvm_load_o <= 1'b0;
      fault_clear_o <= 1'b0;
      retry_clear_o <= 1'b0;
      wdog_tickle_o <= 1'b0;
      nvm_busy_d_r <= 1'b0;
    end
    else
    begin
      nvm_busy_d_r <= nvm_busy_i;
      nvm_save_o <= 1'b0;
      nvm_load_o <= 1'b0;
      fault_clear_o <= 1'b0;
      retry_clear_o <= 1'b0;
      wdog_tickle_o <= 1'b0;
      wdog_bit_r <= 1'b0; // device clears the tickle bit itself
      if (nvm_done)
      begin
        save_bit_r <= 1'b0;
        load_bit_r <= 1'b0;
      end
      if (wr_ctrl)
      begin
        key_r <= dat_i[`MPSC_CTRL_KEY_HI:`MPSC_CTRL_KEY_LO];
        // Save without the correct key is ignored to protect the memory
        if (dat_i[`MPSC_CTRL_SAVE] & key_ok)
        begin
          save_bit_r <= 1'b1;
          nvm_save_o <= 1'b1;
        end
        if (dat_i[`MPSC_CTRL_LOAD])
        begin
          load_bit_r <= 1'b1;
          nvm_load_o <= 1'b1;
        end
        fault_clear_o <= dat_i[`MPSC_CTRL_FCLR];
        retry_clear_o <= dat_i[`MPSC_CTRL_RCLR];
      end
      if (wr & (idx == `MPSC_IDX_CTRL) & sel_i[2] & (|sel_i[1]))
        angle_r <= dat_i[`MPSC_CTRL_ANG_HI:`MPSC_CTRL_ANG_LO];
      if (wr & (idx == `MPSC_IDX_CTRL) & sel_i[1] & dat_i[`MPSC_CTRL_WDOG])
      begin
        wdog_bit_r <= 1'b1;
        wdog_tickle_o <= 1'b1;
      end
    end
  end

  // Align angle and watchdog: count cycles since the last tickle or timeout
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      align_angle_o <= 9'h000;
      wdog_cnt_r <= 32'h0000_0000;
      wdog_timeout_o <= 1'b0;
    end
    else
    begin
      align_angle_o <= angle_r;
      if (~wdog_en_i | wdog_tickle_o)
        wdog_cnt_r <= 32'h0000_0000;
      else if (wdog_expire)
        wdog_cnt_r <= 32'h0000_0000;
      else
        wdog_cnt_r <= wdog_cnt_r + 32'd1;
      wdog_timeout_o <= wdog_expire & ~wdog_tickle_o;
    end
  end

  // Interrupt sources; a new event beats a simultaneous write-one clear
  always @*
  begin
    irq_set = {`MPSC_IRQ_BITS{1'b0}};
    irq_set[`MPSC_IRQ_R] = r_done_i;
    irq_set[`MPSC_IRQ_L] = l_done_i;
    irq_set[`MPSC_IRQ_KE] = ke_done_i;
    irq_set[`MPSC_IRQ_MECH] = mech_done_i;
    irq_set[`MPSC_IRQ_NVM] = nvm_done;
    irq_set[`MPSC_IRQ_WDOG] = wdog_expire & ~wdog_tickle_o;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_r <= {`MPSC_IRQ_BITS{1'b0}};
      irq_mask_r <= {`MPSC_IRQ_BITS{1'b0}};
    end
    else
    begin
      if (wr & (idx == `MPSC_IDX_IRQ_STAT) & sel_i[0])
        irq_stat_r <= (irq_stat_r & ~dat_i[`MPSC_IRQ_BITS-1:0]) | irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
      if (wr & (idx == `MPSC_IDX_IRQ_MASK) & sel_i[0])
        irq_mask_r <= dat_i[`MPSC_IRQ_BITS-1:0];
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // Read mux; write-only fields and reserved bits read zero, unmapped reads zero
  always @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= `MPSC_RESET_WORD;
    else if (req & ~we_i)
    begin
      case (idx)
        `MPSC_IDX_PARAMS: dat_o <= {res_r, emf_r, ind_r, 8'h00};
        `MPSC_IDX_MSTAT: dat_o <= {r_flag_r, l_flag_r, ke_flag_r, mech_flag_r, freq_r, 24'h00_0000};
        `MPSC_IDX_CTRL: dat_o <= {save_bit_r, load_bit_r, 19'h0_0000, wdog_bit_r, 10'h000};
        `MPSC_IDX_IRQ_STAT: dat_o <= {26'h000_0000, irq_stat_r};
        `MPSC_IDX_IRQ_MASK: dat_o <= {26'h000_0000, irq_mask_r};
        `MPSC_IDX_OPSTAT: dat_o <= {30'h0000_0000, wdog_en_i, nvm_busy_i};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule // mpsc_top
`default_nettype wire

// file: mpsc_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module mpsc_chk #(parameter NVM_KEY = 8'h5a) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic nvm_save_o,
  input wire logic nvm_load_o,
  input wire logic fault_clear_o,
  input wire logic wdog_tickle_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Control write taken at this edge; ack low keeps a held strobe out
  wire wr_x = cyc_i && stb_i && we_i && !ack_o && adr_i[9:2] == 8'hea;
  wire rd_p = ack_o && !we_i && adr_i[9:2] == 8'he6;
  wire rd_s = ack_o && !we_i && adr_i[9:2] == 8'he8;
  a_ack_one_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_params_rsv: assert property (rd_p |-> dat_o[7:0] == 8'h00) else $error("low byte set");
  a_status_rsv: assert property (rd_s |-> dat_o[23:0] == 24'h0) else $error("status low set");
  a_save_cause: assert property (nvm_save_o |-> $past(wr_x && sel_i[3] && dat_i[31] && dat_i[27:20] == NVM_KEY))
    else $error("stray save");
  a_load_cause: assert property (nvm_load_o |-> $past(wr_x && sel_i[3] && dat_i[30])) else $error("stray load");
  a_fclr_fire: assert property (wr_x && sel_i[3] && dat_i[29] |=> fault_clear_o) else $error("no clear");
  a_fclr_cause: assert property (fault_clear_o |-> $past(wr_x && dat_i[29])) else $error("stray clear");
  a_tickle_cause: assert property (wdog_tickle_o |-> $past(wr_x && sel_i[1] && dat_i[10]))
    else $error("stray tickle");
  a_reset_quiet: assert property ($fell(rst_i) |-> dat_o == 32'h0 && !irq_o) else $error("not reset");
endmodule // mpsc_chk
bind mpsc_top mpsc_chk #(.NVM_KEY(NVM_KEY)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .nvm_save_o, .nvm_load_o, .fault_clear_o, .wdog_tickle_o, .irq_o);
`default_nettype wire

// file: test_mpsc_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_mpsc_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, irq_a = 1'b0;
  logic r_done_i = 1'b0, l_done_i = 1'b0, ke_done_i = 1'b0, mech_done_i = 1'b0;
  logic nvm_busy_i = 1'b0, wdog_en_i = 1'b0;
  logic [7:0] r_val_i = 8'h0, l_val_i = 8'h0, ke_val_i = 8'h0;
  logic [3:0] freq_val_i = 4'h0, sel_i = 4'hf;
  logic [9:0] adr_i = 10'h0;
  logic [31:0] dat_i = 32'h0, rd;
  wire [31:0] dat_o;
  wire [8:0] align_angle_o;
  wire ack_o, nvm_save_o, nvm_load_o, fault_clear_o, retry_clear_o, wdog_tickle_o, wdog_timeout_o, irq_o;
  int err_count = 0, check_count = 0, cyc_n = 0;
  logic [9:0] adrs [4] = '{10'h398, 10'h3a0, 10'h3a8, 10'h000};
  logic [31:0] cw [3] = '{32'h80000000, 32'h85a00000, 32'h40000000};
  logic [31:0] ce [3] = '{32'h0, 32'h80000000, 32'h40000000};
  // Short watchdog so the timeout shows within a few cycles
  mpsc_top #(.NVM_KEY(8'h5a), .WDOG_CYCLES(32'd20)) dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .r_done_i, .r_val_i, .l_done_i, .l_val_i, .ke_done_i, .ke_val_i,
    .mech_done_i, .freq_val_i, .nvm_busy_i, .wdog_en_i, .nvm_save_o, .nvm_load_o, .fault_clear_o,
    .retry_clear_o, .align_angle_o, .wdog_tickle_o, .wdog_timeout_o, .irq_o);
  always #4 clk_i = ~clk_i;
  task summarize;
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far above the roughly 115 cycles the run needs
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000)
    begin
      err_count++;
      summarize();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle; read data taken at the ack edge, idle cycle follows
  task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b0, adrs[i], 32'h0);
      chk(rd, 32'h0);
    end
    @(posedge clk_i);
    {r_val_i, ke_val_i, l_val_i, freq_val_i} <= {24'h123456, 4'h9};
    {r_done_i, l_done_i, ke_done_i, mech_done_i} <= 4'hf;
    @(posedge clk_i);
    {r_done_i, l_done_i, ke_done_i, mech_done_i} <= 4'h0;
    {r_val_i, ke_val_i, l_val_i, freq_val_i} <= {24'heeddcc, 4'h3};
    wb(1'b1, 10'h398, 32'hffffffff);
    wb(1'b1, 10'h3a0, 32'hffffffff);
    wb(1'b0, 10'h398, 32'h0);
    chk(rd, 32'h12345600);
    wb(1'b0, 10'h3a0, 32'h0);
    chk(rd, 32'hf9000000);
    // Mask polarity is left open, so only the change of irq is judged
    wb(1'b0, 10'h3e0, 32'h0);
    chk(rd, 32'h0000000f);
    wb(1'b1, 10'h3e8, 32'h0);
    irq_a = irq_o;
    wb(1'b1, 10'h3e8, 32'h3f);
    chk({31'h0, irq_a ^ irq_o}, 32'h1);
    wb(1'b1, 10'h3e0, 32'h3f);
    chk({31'h0, irq_o}, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      nvm_busy_i <= 1'b1;
      wb(1'b1, 10'h3a8, cw[i]);
      chk({30'h0, nvm_save_o, nvm_load_o}, {30'h0, ce[i][31:30]});
      wb(1'b0, 10'h3a8, 32'h0);
      chk(rd, ce[i]);
      @(posedge clk_i);
      nvm_busy_i <= 1'b0;
      wb(1'b0, 10'h3a8, 32'h0);
      chk(rd, 32'h0);
    end
    wb(1'b1, 10'h3a8, {4'h3, 8'h00, 9'h15a, 1'b1, 10'h3ff});
    chk({29'h0, fault_clear_o, retry_clear_o, wdog_tickle_o}, 32'h7);
    // The angle output is registered once more, so it shows one edge later
    @(posedge clk_i);
    chk({23'h0, align_angle_o}, 32'h15a);
    wb(1'b0, 10'h3a8, 32'h0);
    chk(rd, 32'h0);
    @(posedge clk_i);
    wdog_en_i <= 1'b1;
    repeat (30) @(posedge clk_i);
    wb(1'b0, 10'h3e0, 32'h0);
    chk(rd, 32'h30);
    summarize();
  end
endmodule // test_mpsc_top
`default_nettype wire
